// File: rtl/pwm_cfg_pkg.sv
// Purpose: Shared constants for the PWM duty limit and compensation block
// Assumes: 8-bit register port decoded from the serial configuration bus
// Notes:   Clock rate and switching rates set the per-period cycle counts

package pwm_cfg_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] INTERLEAVE_ADDR = 8'h04;
  localparam logic [7:0] DUTY_CEIL_ADDR  = 8'h09;
  localparam logic [7:0] PROP_ADDR       = 8'h0A;
  localparam logic [7:0] INTEG_ADDR      = 8'h0B;
  localparam logic [7:0] DERIV_ADDR      = 8'h0C;
  localparam logic [7:0] ROLLOFF_ADDR    = 8'h0D;
  localparam logic [7:0] IDENT_CTRL_ADDR = 8'h0E;
  localparam logic [7:0] IDENT_HI_ADDR   = 8'h0F;
  localparam logic [7:0] IDENT_LO_ADDR   = 8'h10;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int         CEIL_LSB        = 2;
  localparam int         FRQ_BIT         = 5;
  localparam int         MODE_LSB        = 6;
  localparam logic [5:0] DUTY_CEIL_RESET = 6'h3A;
  localparam logic [3:0] PHASE_RESET     = 4'h0;
  localparam logic       FRQ_RESET       = 1'b0;
  localparam logic [7:0] PROP_RESET      = 8'h10;
  localparam logic [7:0] INTEG_RESET     = 8'h01;
  localparam logic [7:0] DERIV_RESET     = 8'h00;
  localparam logic [7:0] ROLLOFF_RESET   = 8'h80;

  // ----------------------------------------------------------------
  // Timing and scaling
  // ----------------------------------------------------------------
  localparam int         CLK_KHZ       = 125000;
  localparam int         SLOW_KHZ      = 500;
  localparam int         FAST_KHZ      = 1000;
  localparam logic [7:0] SLOW_PERIOD   = 8'(CLK_KHZ / SLOW_KHZ);
  localparam logic [7:0] FAST_PERIOD   = 8'(CLK_KHZ / FAST_KHZ);
  localparam int         PHASE_SHIFT   = 4;
  localparam int         DUTY_BITS     = 10;
  localparam int         CEIL_SHIFT    = 4;
  localparam int         GAIN_SHIFT    = 8;
  localparam int         ROLLOFF_SHIFT = 8;
  localparam logic [9:0] INJECT_STEP   = 10'h010;

endpackage : pwm_cfg_pkg

// File: rtl/prbs_gen.sv
// Purpose: Maximal-length pseudo-random bit source for plant identification
// Assumes: step is a one-cycle enable
// Notes:   Seed is nonzero so the register can never lock up

`timescale 1ns/1ps

module prbs_gen #(
  parameter int WIDTH = 7
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Control
  input  wire logic step,
  // Output
  output logic      bit_out
);

  logic [WIDTH-1:0] lfsr_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lfsr_q <= {{(WIDTH-1){1'b0}}, 1'b1};
    end else if (step) begin
      lfsr_q <= {lfsr_q[WIDTH-2:0], lfsr_q[WIDTH-1] ^ lfsr_q[WIDTH-2]};
    end
  end

  assign bit_out = lfsr_q[WIDTH-1];

endmodule : prbs_gen

// File: rtl/pwm_duty_limit_compensation.sv
// Purpose: Digital PWM with duty ceiling, interleave and PID compensation
// Assumes: Register port and all inputs synchronous to clk
// Notes:   One PWM period per sync_line falling edge; free-runs if sync stops
//
// Overview of operation
// - Six-bit ceiling in bits 7:2 caps duty at code/64.
// - Host writes the ceiling register at 0x09; value becomes new duty limit.
// - Feedback moves duty away from the voltage ratio but never past the ceiling.
// - PID correction uses proportional, integral, derivative, roll-off coefficient registers.
// - Identification injects PRBS into the duty and captures the voltage response.
// - Zero interleave phase starts every cycle right at the sync reference.
// - Each switching cycle starts delayed by its programmed interleave phase.
// - Switching aligns to the falling edge of the sync line.
// - Interleave phase selected in its own register in 22.5 degree steps.

`timescale 1ns/1ps

module pwm_duty_limit_compensation #(
  parameter int         PRBS_WIDTH = 7,
  parameter logic [1:0] PHASE_MODE = 2'h0
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  // Converter control and feedback
  input  wire logic        conv_on,
  input  wire logic        sync_line,
  input  wire logic [9:0]  ff_ratio,
  input  wire logic [11:0] err_sample,
  input  wire logic        err_valid,
  // Power stage
  output logic             pwm_out
);

  typedef struct packed {
    logic [5:0]         ceil;
    logic [3:0]         phase;
    logic               frq;
    logic [7:0]         kp;
    logic [7:0]         ki;
    logic [7:0]         kd;
    logic [7:0]         b1;
    logic               id_en;
    logic [11:0]        cap;
    logic               cap_bit;
    logic               sync_prev;
    logic [7:0]         cnt;
    logic [7:0]         offset;
    logic [7:0]         on_cyc;
    logic [9:0]         duty;
    logic signed [11:0] e1;
    logic signed [23:0] integ;
    logic signed [21:0] dfilt;
    logic               pwm;
    logic [7:0]         rdata;
  } state_type;

  state_type s_q;
  state_type s_d;
  logic      prbs_bit;
  logic      sync_fall;

  function automatic logic [7:0] period_of(input logic fast);
    period_of = fast ? pwm_cfg_pkg::FAST_PERIOD : pwm_cfg_pkg::SLOW_PERIOD;
  endfunction : period_of

  assign sync_fall = s_q.sync_prev & ~sync_line;

  prbs_gen #(
    .WIDTH   (PRBS_WIDTH)
  ) u_prbs (
    .clk     (clk),
    .rst     (rst),
    .step    (sync_fall & s_q.id_en),
    .bit_out (prbs_bit)
  );

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic [7:0]         per;
    logic [7:0]         pos;
    logic [11:0]        ofs_prod;
    logic [17:0]        on_prod;
    logic [9:0]         limit;
    logic signed [12:0] de;
    logic signed [19:0] p_term;
    logic signed [23:0] integ_n;
    logic signed [21:0] deriv;
    logic signed [30:0] roll;
    logic signed [21:0] dfilt_n;
    logic signed [26:0] sum;
    logic               sat;
    per      = period_of(s_q.frq);
    pos      = 8'h00;
    ofs_prod = 12'h000;
    on_prod  = 18'h00000;
    limit    = {s_q.ceil, 4'h0};
    de       = 13'sh0000;
    p_term   = 20'sh00000;
    integ_n  = 24'sh000000;
    deriv    = 22'sh000000;
    roll     = 31'sh00000000;
    dfilt_n  = 22'sh000000;
    sum      = 27'sh0000000;
    sat      = 1'b0;
    s_d      = s_q;

    // Register writes
    if (reg_wr) begin
      unique case (reg_addr)
        pwm_cfg_pkg::INTERLEAVE_ADDR: begin
          s_d.phase = reg_wdata[3:0];
          // Switching rate may change only while the converter is off
          if (!conv_on) begin
            s_d.frq = reg_wdata[pwm_cfg_pkg::FRQ_BIT];
          end
        end
        pwm_cfg_pkg::DUTY_CEIL_ADDR:  s_d.ceil = reg_wdata[7:pwm_cfg_pkg::CEIL_LSB];
        pwm_cfg_pkg::PROP_ADDR:       s_d.kp = reg_wdata;
        pwm_cfg_pkg::INTEG_ADDR:      s_d.ki = reg_wdata;
        pwm_cfg_pkg::DERIV_ADDR:      s_d.kd = reg_wdata;
        pwm_cfg_pkg::ROLLOFF_ADDR:    s_d.b1 = reg_wdata;
        pwm_cfg_pkg::IDENT_CTRL_ADDR: s_d.id_en = reg_wdata[0];
        default: ;
      endcase
    end

    // Register reads
    if (reg_rd) begin
      unique case (reg_addr)
        pwm_cfg_pkg::INTERLEAVE_ADDR: s_d.rdata = {PHASE_MODE, s_q.frq, 1'b0, s_q.phase};
        pwm_cfg_pkg::DUTY_CEIL_ADDR:  s_d.rdata = {s_q.ceil, 2'b00};
        pwm_cfg_pkg::PROP_ADDR:       s_d.rdata = s_q.kp;
        pwm_cfg_pkg::INTEG_ADDR:      s_d.rdata = s_q.ki;
        pwm_cfg_pkg::DERIV_ADDR:      s_d.rdata = s_q.kd;
        pwm_cfg_pkg::ROLLOFF_ADDR:    s_d.rdata = s_q.b1;
        pwm_cfg_pkg::IDENT_CTRL_ADDR: s_d.rdata = {7'h00, s_q.id_en};
        pwm_cfg_pkg::IDENT_HI_ADDR:   s_d.rdata = {s_q.cap_bit, 3'h0, s_q.cap[11:8]};
        pwm_cfg_pkg::IDENT_LO_ADDR:   s_d.rdata = s_q.cap[7:0];
        default:                      s_d.rdata = 8'h00;
      endcase
    end

    // Period counter restarts on each falling sync edge
    s_d.sync_prev = sync_line;
    if (sync_fall) begin
      s_d.cnt = 8'h00;
    end else if (s_q.cnt >= per - 8'h01) begin
      s_d.cnt = 8'h00;
    end else begin
      s_d.cnt = s_q.cnt + 8'h01;
    end

    // Phase lag of 1/16 period per step
    ofs_prod = {4'h0, s_q.phase} * {4'h0, per};
    s_d.offset = ofs_prod[11:pwm_cfg_pkg::PHASE_SHIFT];
    if (s_q.cnt >= s_q.offset) begin
      pos = s_q.cnt - s_q.offset;
    end else begin
      pos = s_q.cnt + per - s_q.offset;
    end
    s_d.pwm = (pos < s_q.on_cyc);

    // High-time in clock cycles from the 10-bit duty fraction
    on_prod = {8'h00, s_q.duty} * {10'h000, per};
    s_d.on_cyc = on_prod[17:pwm_cfg_pkg::DUTY_BITS];

    // PID update on each new error sample
    if (err_valid) begin
      de      = 13'(signed'(err_sample)) - 13'(s_q.e1);
      p_term  = signed'(err_sample) * signed'(s_q.kp);
      integ_n = s_q.integ + 24'(signed'(err_sample)) * 24'(signed'(s_q.ki));
      deriv   = 22'(de) * 22'(signed'(s_q.kd));
      roll    = (31'(deriv) - 31'(s_q.dfilt)) * 31'(signed'({1'b0, s_q.b1}));
      dfilt_n = s_q.dfilt + 22'(roll >>> pwm_cfg_pkg::ROLLOFF_SHIFT);
      sum     = 27'(signed'({1'b0, ff_ratio}))
              + 27'((27'(p_term) + 27'(integ_n) + 27'(dfilt_n)) >>> pwm_cfg_pkg::GAIN_SHIFT);
      if (s_q.id_en) begin
        sum = prbs_bit ? sum + 27'(signed'({1'b0, pwm_cfg_pkg::INJECT_STEP}))
                       : sum - 27'(signed'({1'b0, pwm_cfg_pkg::INJECT_STEP}));
        s_d.cap     = err_sample;
        s_d.cap_bit = prbs_bit;
      end
      // Clamp to the ceiling; freeze integrator while saturated
      if (sum < 27'sh0) begin
        s_d.duty = 10'h000;
        sat = 1'b1;
      end else if (sum > 27'(signed'({1'b0, limit}))) begin
        s_d.duty = limit;
        sat = 1'b1;
      end else begin
        s_d.duty = sum[9:0];
      end
      s_d.e1    = signed'(err_sample);
      s_d.dfilt = dfilt_n;
      if (!sat) begin
        s_d.integ = integ_n;
      end
    end else if (s_q.duty > limit) begin
      // A lowered ceiling takes effect without waiting for a sample
      s_d.duty = limit;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '{ceil: pwm_cfg_pkg::DUTY_CEIL_RESET, phase: pwm_cfg_pkg::PHASE_RESET,
               frq: pwm_cfg_pkg::FRQ_RESET, kp: pwm_cfg_pkg::PROP_RESET,
               ki: pwm_cfg_pkg::INTEG_RESET, kd: pwm_cfg_pkg::DERIV_RESET,
               b1: pwm_cfg_pkg::ROLLOFF_RESET, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata = s_q.rdata;
  assign pwm_out   = s_q.pwm;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence sync_fall_s;
    s_q.sync_prev && !sync_line;
  endsequence

  duty_under_ceiling_a: assert property (@(posedge clk) disable iff (rst)
    ##1 s_q.duty <= {$past(s_q.ceil), 4'h0})
    else $error("duty above ceiling");
  zero_ceiling_off_a: assert property (@(posedge clk) disable iff (rst)
    (s_q.ceil == 6'h00) [*4] |-> !pwm_out)
    else $error("pwm high with zero ceiling");
  ceiling_write_a: assert property (@(posedge clk) disable iff (rst)
    reg_wr && reg_addr == pwm_cfg_pkg::DUTY_CEIL_ADDR |=> s_q.ceil == $past(reg_wdata[7:2]))
    else $error("ceiling write not applied");
  ceiling_low_zero_a: assert property (@(posedge clk) disable iff (rst)
    reg_rd && reg_addr == pwm_cfg_pkg::DUTY_CEIL_ADDR |=> reg_rdata[1:0] == 2'b00)
    else $error("ceiling low bits not zero");
  coeff_write_a: assert property (@(posedge clk) disable iff (rst)
    reg_wr && reg_addr == pwm_cfg_pkg::PROP_ADDR |=> s_q.kp == $past(reg_wdata))
    else $error("coefficient write lost");
  ident_capture_a: assert property (@(posedge clk) disable iff (rst)
    err_valid && s_q.id_en |=> s_q.cap == $past(err_sample) && s_q.cap_bit == $past(prbs_bit))
    else $error("response not captured");
  sync_align_a: assert property (@(posedge clk) disable iff (rst)
    sync_fall_s |=> s_q.cnt == 8'h00)
    else $error("period not aligned to sync");
  zero_phase_start_a: assert property (@(posedge clk) disable iff (rst)
    s_q.cnt == 8'h00 && s_q.offset == 8'h00 && s_q.on_cyc != 8'h00 |=> pwm_out)
    else $error("cycle not started at reference");
  phase_delay_a: assert property (@(posedge clk) disable iff (rst)
    s_q.offset != 8'h00 && s_q.cnt == s_q.offset - 8'h01 && s_q.on_cyc < period_of(s_q.frq)
    |=> !pwm_out ##1 1'b1)
    else $error("cycle started before its phase");
  offset_value_a: assert property (@(posedge clk) disable iff (rst)
    ##1 s_q.offset == 8'((12'($past(s_q.phase)) * 12'(period_of($past(s_q.frq)))) >> 4))
    else $error("phase offset wrong");

endmodule : pwm_duty_limit_compensation

// File: test/host_model.sv
// Purpose: Configuration host that writes and reads the register port
// Assumes: Strobes change on the falling clock edge, one cycle wide
// Notes:   Write data is scrambled once a write completes

`timescale 1ns/1ps

module host_model (
  // Clock
  input  wire logic       clk,
  // Register port
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata
);
  initial begin
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge clk);
    reg_wr    = 1'b0;
    // Stale data must not look valid once the strobe is gone
    reg_wdata = ~d;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge clk);
    reg_rd   = 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask : rd
endmodule : host_model

// File: test/testbench.sv
// Purpose: Self-checking bench for the PWM duty limit block
// Assumes: 125 MHz clock, 500 kHz switching, 250 cycles per period
// Notes:   PWM timing is counted in clock cycles after the sync fall

`timescale 1ns/1ps

module testbench;
  logic        clk;
  logic        rst;
  logic        conv_on;
  logic        sync_line;
  logic        err_valid;
  logic        pwm_out;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic [7:0]  reg_rdata;
  logic [9:0]  ff_ratio;
  logic [11:0] err_sample;
  logic [7:0]  v;
  int          bad_count;
  int          n_checks;

  host_model host (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  pwm_duty_limit_compensation #(.PRBS_WIDTH(7), .PHASE_MODE(2'h0))
    u_pwm_duty_limit_compensation (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .conv_on(conv_on), .sync_line(sync_line), .ff_ratio(ff_ratio),
    .err_sample(err_sample), .err_valid(err_valid), .pwm_out(pwm_out));

  // ----------------------------------------------------------------
  // Reporting
  // ----------------------------------------------------------------
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : final_report

  task automatic chk_reg(input string name, input logic [7:0] a, input logic [7:0] exp);
    host.rd(a, v);
    n_checks++;
    if (v !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", name, exp, v);
    end
  endtask : chk_reg

  task automatic chk_cnt(input string name, input int exp, input int got);
    n_checks++;
    if (got != exp) begin
      bad_count++;
      $display("mismatch %s expected %0d seen %0d", name, exp, got);
    end
  endtask : chk_cnt

  // ----------------------------------------------------------------
  // Stimulus helpers
  // ----------------------------------------------------------------
  task automatic fb(input logic [11:0] e);
    @(negedge clk);
    err_sample = e;
    err_valid  = 1'b1;
    @(negedge clk);
    err_valid  = 1'b0;
  endtask : fb

  // Restart the period just after a high phase ends, so the old cycle
  // cannot leak into the measured delay
  task automatic pwm_check(input string name, input int dly, input int hi);
    int k;
    int h;
    k = 0;
    while (pwm_out !== 1'b1 && k < 300) begin @(negedge clk); k++; end
    while (pwm_out !== 1'b0 && k < 600) begin @(negedge clk); k++; end
    sync_line = 1'b0;
    @(negedge clk);
    sync_line = 1'b1;
    k = 0;
    while (pwm_out !== 1'b1 && k < 300) begin @(negedge clk); k++; end
    h = 0;
    while (pwm_out === 1'b1 && h < 300) begin @(negedge clk); h++; end
    chk_cnt({name, " delay"}, dly, k);
    chk_cnt({name, " high"}, hi, h);
  endtask : pwm_check

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_reset;
    chk_reg("ceiling reset", 8'h09, 8'hE8);
    chk_reg("interleave reset", 8'h04, 8'h00);
    chk_reg("kp reset", 8'h0A, 8'h10);
    chk_reg("ki reset", 8'h0B, 8'h01);
    chk_reg("kd reset", 8'h0C, 8'h00);
    chk_reg("rolloff reset", 8'h0D, 8'h80);
    chk_reg("unmapped", 8'h01, 8'h00);
  endtask : test_reset

  task automatic test_regs;
    host.wr(8'h09, 8'hFF);
    chk_reg("ceiling low bits", 8'h09, 8'hFC);
    for (int a = 8'h0A; a <= 8'h0D; a++) begin
      host.wr(8'(a), 8'h5A);
      chk_reg("coefficient", 8'(a), 8'h5A);
      host.wr(8'(a), 8'h00);
    end
  endtask : test_regs

  task automatic test_pid;
    fb(12'h000);
    pwm_check("ratio only", 1, 125);
    host.wr(8'h0A, 8'h40);
    fb(12'h100);
    pwm_check("proportional", 1, 140);
  endtask : test_pid

  task automatic test_ceiling;
    host.wr(8'h09, 8'h40);
    pwm_check("ceiling 16", 1, 62);
    host.wr(8'h09, 8'h00);
    pwm_check("ceiling 0", 300, 0);
    host.wr(8'h09, 8'hFC);
    host.wr(8'h0A, 8'h00);
    fb(12'h000);
  endtask : test_ceiling

  task automatic test_phase;
    host.wr(8'h04, 8'h28);
    chk_reg("rate locked", 8'h04, 8'h08);
    pwm_check("phase 8", 126, 125);
    host.wr(8'h04, 8'h04);
    pwm_check("phase 4", 63, 125);
    // Rate bit only takes a write while the converter is off
    conv_on = 1'b0;
    host.wr(8'h04, 8'h20);
    chk_reg("rate unlocked", 8'h04, 8'h20);
    pwm_check("fast zero phase", 1, 62);
  endtask : test_phase

  task automatic test_ident;
    host.wr(8'h0E, 8'h01);
    fb(12'h123);
    chk_reg("capture low", 8'h10, 8'h23);
    chk_reg("capture high", 8'h0F, 8'h01);
    // Six sync falls walk the sequence to its first one bit
    repeat (6) begin
      @(negedge clk);
      sync_line = 1'b0;
      @(negedge clk);
      sync_line = 1'b1;
    end
    fb(12'h045);
    chk_reg("capture bit", 8'h0F, 8'h80);
    pwm_check("injected", 1, 64);
  endtask : test_ident

  task automatic test_mid_reset;
    @(negedge clk);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    test_reset();
    chk_reg("ident reset", 8'h0E, 8'h00);
    chk_reg("capture reset", 8'h10, 8'h00);
  endtask : test_mid_reset

  // ----------------------------------------------------------------
  // Clock, reset, sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial begin
    bad_count  = 0;
    n_checks   = 0;
    rst        = 1'b1;
    conv_on    = 1'b1;
    sync_line  = 1'b1;
    err_valid  = 1'b0;
    err_sample = 12'h000;
    ff_ratio   = 10'h200;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    test_reset();
    test_regs();
    test_pid();
    test_ceiling();
    test_phase();
    test_ident();
    test_mid_reset();
    final_report();
  end

  // Whole sequence needs about 2600 cycles
  initial begin
    #200000;
    bad_count++;
    final_report();
  end
endmodule : testbench
